// >>> core/wdt_core.v
// Purpose: Watchdog timer with key-field software reset, reset flags and power-on reset hold
// Assumes: CPU pulses (kick, halt, wake) are on pclk; oscillator and strap pins are asynchronous
// Notes:   Registers reached over APB with one wait state; presetn is the power-on reset
//          Slow clocks are sampled on pclk, so they must run far below a third of pclk
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_map.vh"

module wdt_core #(
	parameter RSTD_CYC = `WDT_TRSTD_CYC
) (
	// APB clock and power-on reset
	input  wire        pclk,
	input  wire        presetn,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// Oscillator and configuration pins
	input  wire        external_crystal_clock,
	input  wire        internal_slow_oscillator,
	input  wire        clk_src_crystal_strap,
	// CPU events
	input  wire        kick_instruction,
	input  wire        halt_exec,
	input  wire        halt_to_idle,
	input  wire        wake_event,
	// Reset and system outputs
	output reg         core_reset_n,
	output reg         pc_sp_clear,
	output reg         watchdog_expired_flag,
	output reg         idle_system_clock_keep,
	output reg  [7:0]  port_data,
	output reg  [7:0]  port_dir
);

	// Sequencer states, one-hot
	localparam [2:0] ST_POR  = 3'h1;
	localparam [2:0] ST_RUN  = 3'h2;
	localparam [2:0] ST_HOLD = 3'h4;

	// Hold length cut to the counter width on purpose; the default fits in 24 bits
	localparam [31:0]            HOLD_FULL = RSTD_CYC - 1;
	localparam [`WDT_HOLD_W-1:0] HOLD_LAST = HOLD_FULL[`WDT_HOLD_W-1:0];
	localparam [1:0]             DEB_LAST  = `WDT_KEY_DEB_EDGES - 2'h1;

	reg  [2:0]             state;
	reg  [`WDT_HOLD_W-1:0] hold_cnt;
	reg  [7:0]             watchdog_control;
	reg  [7:0]             sys_store;
	reg                    key_reset_flag;
	reg                    src_crystal;
	reg                    asleep;
	reg                    idling;
	reg  [1:0]             deb_cnt;
	reg  [31:0]            rd_data;
	reg                    addr_hit;
	reg                    next_core_reset_n;
	reg                    next_pc_sp_clear;

	wire [2:0]             sync_level;
	wire [2:0]             sync_rise;
	wire [`WDT_CNT_W-1:0]  wdt_count_val;
	wire                   wdt_overflow;

	// Key, tick and reset causes
	wire        run        = (state == ST_RUN);
	wire [4:0]  enable_key_field    = watchdog_control[`WDT_KEY_MSB:`WDT_KEY_LSB];
	wire [2:0]  period_select_field = watchdog_control[`WDT_SEL_MSB:`WDT_SEL_LSB];
	wire        key_ok     = (enable_key_field == `WDT_KEY_A) || (enable_key_field == `WDT_KEY_B);
	wire        internal_slow_oscillator_rise  = sync_rise[1];
	wire        low_speed_clock_rise = src_crystal ? sync_rise[0] : sync_rise[1];
	wire        key_fire   = run && !key_ok && internal_slow_oscillator_rise && (deb_cnt == DEB_LAST);
	wire        halt_go    = run && halt_exec;
	wire        kick_go    = run && kick_instruction;
	wire        powered_down = asleep || idling;
	wire        ovf_full   = run && wdt_overflow && !powered_down;
	wire        ovf_warm   = run && wdt_overflow && powered_down;
	// APB decode; a write lands at the edge that sees pready high
	wire        apb_access = psel && penable;
	wire        apb_commit = apb_access && pready;
	wire        wr_go      = apb_commit && pwrite;
	wire        wr_ctl     = wr_go && (paddr == `WDT_OFS_CONTROL);
	wire        wr_sys     = wr_go && (paddr == `WDT_OFS_SYSCTL);
	wire        wr_pdata   = wr_go && (paddr == `WDT_OFS_PORT_DATA);
	wire        wr_pdir    = wr_go && (paddr == `WDT_OFS_PORT_DIR);

	// Slow clocks counted as edges on pclk; pclk must far outrun them
	wdt_sync #(
		.W        (3)
	) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in ({clk_src_crystal_strap, internal_slow_oscillator, external_crystal_clock}),
		.level    (sync_level),
		.rise     (sync_rise)
	);

	// Counter held clear outside run; ticks stop while asleep or with a bad key
	wdt_count #(
		.CW       (`WDT_CNT_W)
	) u_count (
		.pclk     (pclk),
		.presetn  (presetn),
		.clr      (!run || key_fire || kick_go || halt_go),
		.tick     (run && key_ok && !asleep && low_speed_clock_rise),
		.sel      (period_select_field),
		.count    (wdt_count_val),
		.overflow (wdt_overflow)
	);

	// Reset sequencer: power-on hold, then device resets from key or time-out
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state    <= ST_POR;
			hold_cnt <= {`WDT_HOLD_W{1'b0}};
		end else begin
			case (state)
				ST_POR: begin
					if (hold_cnt == HOLD_LAST) begin
						state    <= ST_RUN;
						hold_cnt <= {`WDT_HOLD_W{1'b0}};
					end else begin
						hold_cnt <= hold_cnt + {{(`WDT_HOLD_W-1){1'b0}}, 1'b1};
					end
				end
				ST_RUN: begin
					if (key_fire || ovf_full) begin
						state    <= ST_HOLD;
						hold_cnt <= {`WDT_HOLD_W{1'b0}};
					end
				end
				// Internal resets reuse the power-on hold length
				ST_HOLD: begin
					if (hold_cnt == HOLD_LAST) begin
						state    <= ST_RUN;
						hold_cnt <= {`WDT_HOLD_W{1'b0}};
					end else begin
						hold_cnt <= hold_cnt + {{(`WDT_HOLD_W-1){1'b0}}, 1'b1};
					end
				end
				default: begin
					state    <= ST_POR;
					hold_cnt <= {`WDT_HOLD_W{1'b0}};
				end
			endcase
		end
	end

	// Source strap caught while the power-on hold lasts, then frozen
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_crystal <= 1'b0;
		end else if (state == ST_POR) begin
			src_crystal <= sync_level[2];
		end
	end

	// Key debounce in slow oscillator edges; a key restored in time cancels it
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			deb_cnt <= 2'h0;
		end else if (!run || key_ok || key_fire) begin
			deb_cnt <= 2'h0;
		end else if (internal_slow_oscillator_rise) begin
			deb_cnt <= deb_cnt + 2'h1;
		end
	end

	// Control register survives a time-out reset, reloads on the others
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			watchdog_control <= `WDT_CONTROL_RST;
		end else if (key_fire) begin
			watchdog_control <= `WDT_CONTROL_RST;
		end else if (wr_ctl) begin
			watchdog_control <= pwdata[7:0];
		end
	end

	// System control: stored bits, bit 6 never stored, flag set wins
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sys_store      <= `WDT_SYSCTL_RST;
			key_reset_flag <= 1'b0;
		end else begin
			if (wr_sys) begin
				sys_store <= pwdata[7:0] & `WDT_SC_STORE_MASK;
			end
			// Key flag: hardware only ever sets it, software clears it with a zero
			if (key_fire) begin
				key_reset_flag <= 1'b1;
			end else if (wr_sys && !pwdata[`WDT_SC_KEYFLAG]) begin
				key_reset_flag <= 1'b0;
			end
		end
	end

	// Power-down tracking; a warm time-out wakes the core
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			asleep <= 1'b0;
			idling <= 1'b0;
		end else if (!run || wake_event || ovf_warm) begin
			asleep <= 1'b0;
			idling <= 1'b0;
		end else if (halt_go) begin
			asleep <= !halt_to_idle;
			idling <= halt_to_idle;
		end
	end

	// Expired flag: an overflow wins over a kick or halt in the same cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			watchdog_expired_flag <= 1'b0;
		end else if (wdt_overflow && run) begin
			watchdog_expired_flag <= 1'b1;
		end else if (kick_go || halt_go) begin
			watchdog_expired_flag <= 1'b0;
		end
	end

	// Device reset starts with the event itself, at the same edge the sequencer enters ST_HOLD
	always @* begin
		next_core_reset_n = run;
		next_pc_sp_clear  = !run;
		if (key_fire || ovf_full) begin
			next_core_reset_n = 1'b0;
			next_pc_sp_clear  = 1'b1;
		end
		if (ovf_warm) begin
			next_pc_sp_clear  = 1'b1;
		end
	end

	// Reset outputs; program counter is zero whenever core reset or clear is seen
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_reset_n <= 1'b0;
			pc_sp_clear  <= 1'b1;
		end else begin
			core_reset_n <= next_core_reset_n;
			pc_sp_clear  <= next_pc_sp_clear;
		end
	end

	// Ports start as inputs only after power-on
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_data <= `WDT_PORT_RST;
			port_dir  <= `WDT_PORT_RST;
		end else begin
			if (wr_pdata) begin
				port_data <= pwdata[7:0];
			end
			if (wr_pdir) begin
				port_dir <= pwdata[7:0];
			end
		end
	end

	// Keep bit only mirrored out; the clock control that uses it lives elsewhere
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_system_clock_keep <= 1'b0;
		end else begin
			idle_system_clock_keep <= sys_store[`WDT_SC_KEEP];
		end
	end

	// Read mux
	always @* begin
		rd_data  = 32'h00000000;
		addr_hit = 1'b1;
		case (paddr)
			`WDT_OFS_CONTROL: begin
				rd_data[7:0] = watchdog_control;
			end
			`WDT_OFS_SYSCTL: begin
				rd_data[7:0] = {sys_store[7], 1'b0, sys_store[5:1], key_reset_flag};
			end
			`WDT_OFS_STATUS: begin
				rd_data[`WDT_ST_EXPIRED] = watchdog_expired_flag;
				rd_data[`WDT_ST_SLEEP]   = asleep;
				rd_data[`WDT_ST_IDLE]    = idling;
				rd_data[`WDT_ST_XTAL]    = src_crystal;
			end
			`WDT_OFS_PORT_DATA: begin
				rd_data[7:0] = port_data;
			end
			`WDT_OFS_PORT_DIR: begin
				rd_data[7:0] = port_dir;
			end
			default: begin
				addr_hit = 1'b0;
			end
		endcase
	end

	// One wait state keeps pready, prdata and pslverr registered
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else if (apb_access && !pready) begin
			pready  <= 1'b1;
			pslverr <= !addr_hit;
			prdata  <= pwrite ? 32'h00000000 : rd_data;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			// prdata left alone so read data stands until the next access
		end
	end

endmodule // wdt_core

`default_nettype wire

// >>> core/wdt_count.v
// Purpose: Watchdog counter with selectable time-out of 2^N low-speed clock ticks
// Assumes: tick is a one-cycle pulse per low-speed clock edge
// Notes:   Compare is >= so a shorter period chosen mid-count still expires
`timescale 1ns/1ps
`default_nettype none
`include "wdt_map.vh"

module wdt_count #(
	parameter CW = `WDT_CNT_W
) (
	// Clock and reset
	input  wire          pclk,
	input  wire          presetn,
	// Control
	input  wire          clr,
	input  wire          tick,
	input  wire [2:0]    sel,
	// Results
	output reg  [CW-1:0] count,
	output reg           overflow
);

	reg [CW-1:0] limit;

	always @* begin
		case (sel)
			3'h0:    limit = 18'h000FF;
			3'h1:    limit = 18'h003FF;
			3'h2:    limit = 18'h00FFF;
			3'h3:    limit = 18'h03FFF;
			3'h4:    limit = 18'h07FFF;
			3'h5:    limit = 18'h0FFFF;
			3'h6:    limit = 18'h1FFFF;
			default: limit = 18'h3FFFF;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count    <= {CW{1'b0}};
			overflow <= 1'b0;
		end else if (clr) begin
			count    <= {CW{1'b0}};
			overflow <= 1'b0;
		end else if (tick && count >= limit) begin
			count    <= {CW{1'b0}};
			overflow <= 1'b1;
		end else begin
			if (tick) begin
				count <= count + {{(CW-1){1'b0}}, 1'b1};
			end
			overflow <= 1'b0;
		end
	end

endmodule // wdt_count

`default_nettype wire

// >>> core/wdt_sync.v
// Purpose: Two-flop synchronisers with rising-edge detect, one per bit
// Assumes: Inputs asynchronous to pclk
// Notes:   Edge detect looks only at the second and third flops
`timescale 1ns/1ps
`default_nettype none

module wdt_sync #(
	parameter W = 3
) (
	// Clock and reset
	input  wire         pclk,
	input  wire         presetn,
	// Asynchronous inputs
	input  wire [W-1:0] async_in,
	// Synchronised level and rising-edge pulse
	output wire [W-1:0] level,
	output wire [W-1:0] rise
);

	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			reg s1;
			reg s2;
			reg s3;
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					s1 <= 1'b0;
					s2 <= 1'b0;
					s3 <= 1'b0;
				end else begin
					s1 <= async_in[i];
					s2 <= s1;
					s3 <= s2;
				end
			end
			assign level[i] = s2;
			assign rise[i]  = s2 & ~s3;
		end
	endgenerate

endmodule // wdt_sync

`default_nettype wire

// >>> inc/wdt_map.vh
// Purpose: Register offsets, field positions, reset values and timing counts of the watchdog block
// Assumes: APB byte addresses, 32-bit data, 8-bit registers in the low bits
// Notes:   Definitions only
`ifndef WDT_MAP_VH
`define WDT_MAP_VH

// Register byte offsets
`define WDT_OFS_CONTROL     12'h000
`define WDT_OFS_SYSCTL      12'h004
`define WDT_OFS_STATUS      12'h008
`define WDT_OFS_PORT_DATA   12'h00C
`define WDT_OFS_PORT_DIR    12'h010

// Reset values
`define WDT_CONTROL_RST     8'h53
`define WDT_SYSCTL_RST      8'h00
`define WDT_PORT_RST        8'hFF

// Watchdog control fields
`define WDT_KEY_MSB         7
`define WDT_KEY_LSB         3
`define WDT_SEL_MSB         2
`define WDT_SEL_LSB         0
`define WDT_KEY_A           5'h0A
`define WDT_KEY_B           5'h15

// System control fields
`define WDT_SC_KEEP         7
`define WDT_SC_UNIMP        6
`define WDT_SC_KEYFLAG      0
`define WDT_SC_STORE_MASK   8'hBE

// Status fields
`define WDT_ST_EXPIRED      0
`define WDT_ST_SLEEP        1
`define WDT_ST_IDLE         2
`define WDT_ST_XTAL         3

// Timing
`define WDT_CLK_MHZ         200
`define WDT_TRSTD_MS        50
`define WDT_TRSTD_CYC       (`WDT_TRSTD_MS * 1000 * `WDT_CLK_MHZ)
`define WDT_KEY_DEB_EDGES   2'h3
`define WDT_HOLD_W          24
`define WDT_CNT_W           18

`endif

// >>> verif/wdt_core_bench.sv
// Purpose: Self-checking bench of the watchdog block
// Assumes: Reset hold shortened to 20 cycles; slow clocks made from a cycle count
// Notes:   Strap low at first, then high across a second power-on reset for the crystal run
`timescale 1ns/1ps
`default_nettype none
`include "wdt_map.vh"

module wdt_core_bench;
	localparam HOLD = 20;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic        xtal = 1'b0;
	logic        slow = 1'b0;
	logic        strap = 1'b0;
	logic        kick = 1'b0;
	logic        halt = 1'b0;
	logic        idle = 1'b0;
	logic        wake = 1'b0;
	wire  [31:0] prdata;
	wire         pready;
	wire         pslverr;
	wire         rst_n;
	wire         pcsp;
	wire         expd;
	wire         keep;
	wire  [7:0]  pdata;
	wire  [7:0]  pdir;
	logic [31:0] rd;
	logic        err;
	int          k;
	int          cyc = 0;
	int          miscompares = 0;
	int          tests_run = 0;

	wdt_core #(.RSTD_CYC(HOLD)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .external_crystal_clock(xtal), .internal_slow_oscillator(slow),
		.clk_src_crystal_strap(strap), .kick_instruction(kick), .halt_exec(halt),
		.halt_to_idle(idle), .wake_event(wake), .core_reset_n(rst_n), .pc_sp_clear(pcsp),
		.watchdog_expired_flag(expd), .idle_system_clock_keep(keep), .port_data(pdata),
		.port_dir(pdir));

	initial forever #2.5 pclk = ~pclk;

	// Slow clock period is 8 cycles, well below the pclk/3 limit of the synchroniser
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		slow <= cyc[2];
		xtal <= cyc[4];
		if (cyc == 40000) begin
			miscompares++;
			report_and_stop;
		end
	end

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rdchk(input logic [11:0] a, input logic [31:0] e, input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask

	task cpu(input logic h, input logic i);
		@(posedge pclk);
		kick <= !h;
		halt <= h;
		idle <= i;
		@(posedge pclk);
		kick <= 1'b0;
		halt <= 1'b0;
	endtask

	// Stops after n cycles, at a core reset or at a PC/SP clear, whichever comes first
	task wait_for(input int n);
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (k < n && rst_n === 1'b1 && pcsp !== 1'b1);
	endtask

	task wait_run;
		k = 0;
		while (rst_n !== 1'b1 && k < 100) begin
			@(posedge pclk);
			k++;
		end
	endtask

	task t_por;
		chk("pcsp", 1'b1, pcsp);
		chk("port_data", 8'hFF, pdata);
		chk("port_dir", 8'hFF, pdir);
		wait_run;
		chk("hold", 1'b1, k >= HOLD && k <= HOLD + 3);
		chk("pcsp run", 1'b0, pcsp);
		rdchk(`WDT_OFS_CONTROL, 32'h53, "control");
	endtask

	task t_regs;
		apb(1'b1, `WDT_OFS_SYSCTL, 32'hFF);
		repeat (2) @(posedge pclk);
		chk("keep", 1'b1, keep);
		rdchk(`WDT_OFS_SYSCTL, 32'hBE, "sysctl");
		apb(1'b1, `WDT_OFS_SYSCTL, 32'h02);
		rdchk(`WDT_OFS_SYSCTL, 32'h02, "bit1");
		apb(1'b1, `WDT_OFS_SYSCTL, 32'h00);
		apb(1'b1, `WDT_OFS_PORT_DATA, 32'h5A);
		@(posedge pclk);
		chk("port write", 8'h5A, pdata);
		rdchk(12'h0FC, 32'h0, "unmapped");
		chk("pslverr", 1'b1, err);
	endtask

	task t_key;
		apb(1'b1, `WDT_OFS_CONTROL, 32'h00);
		wait_for(100);
		chk("key reset", 1'b0, rst_n);
		chk("debounce", 1'b1, k >= 12 && k <= 40);
		wait_run;
		rdchk(`WDT_OFS_SYSCTL, 32'h01, "key flag");
		rdchk(`WDT_OFS_CONTROL, 32'h53, "control");
		apb(1'b1, `WDT_OFS_SYSCTL, 32'h00);
		rdchk(`WDT_OFS_SYSCTL, 32'h00, "flag clear");
	endtask

	task t_expire;
		apb(1'b1, `WDT_OFS_CONTROL, 32'h50);
		cpu(1'b0, 1'b0);
		repeat (3) begin
			wait_for(1200);
			chk("kicked", 32'd1200, k);
			cpu(1'b0, 1'b0);
		end
		wait_for(2600);
		chk("timeout", 1'b0, rst_n);
		chk("period", 1'b1, k >= 2030 && k <= 2080);
		chk("expired", 1'b1, expd);
		wait_run;
		rdchk(`WDT_OFS_CONTROL, 32'h50, "control kept");
		rdchk(`WDT_OFS_STATUS, 32'h01, "status");
	endtask

	task t_sleep;
		cpu(1'b0, 1'b0);
		repeat (2) @(posedge pclk);
		chk("kick flag", 1'b0, expd);
		cpu(1'b1, 1'b0);
		wait_for(2600);
		chk("asleep", 32'd2600, k);
		@(posedge pclk);
		wake <= 1'b1;
		@(posedge pclk);
		wake <= 1'b0;
		cpu(1'b1, 1'b1);
		wait_for(2600);
		chk("warm", 1'b1, pcsp);
		chk("no core", 1'b1, rst_n);
		chk("idle period", 1'b1, k >= 2030 && k <= 2080);
		repeat (2) @(posedge pclk);
		chk("expired", 1'b1, expd);
	endtask

	task t_xtal;
		@(posedge pclk);
		strap <= 1'b1;
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		chk("pcsp again", 1'b1, pcsp);
		wait_run;
		chk("hold again", 1'b1, k >= HOLD && k <= HOLD + 3);
		rdchk(`WDT_OFS_STATUS, 32'h08, "xtal source");
		apb(1'b1, `WDT_OFS_CONTROL, 32'h50);
		cpu(1'b0, 1'b0);
		wait_for(9000);
		chk("xtal timeout", 1'b0, rst_n);
		chk("xtal period", 1'b1, k >= 8150 && k <= 8250);
	endtask

	task report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_por;
		t_regs;
		t_key;
		t_expire;
		t_sleep;
		t_xtal;
		report_and_stop;
	end
endmodule // wdt_core_bench

`default_nettype wire

// >>> verif/wdt_core_props.sv
// Purpose: Port checks of the watchdog block
// Assumes: APB with one wait state, reset hold of at least 9 cycles
// Notes:   Bound to wdt_core
`timescale 1ns/1ps
`default_nettype none
`include "wdt_map.vh"

module wdt_props (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// CPU and system
	input wire logic        kick_instruction,
	input wire logic        core_reset_n,
	input wire logic        pc_sp_clear,
	input wire logic        watchdog_expired_flag,
	input wire logic        idle_system_clock_keep
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_ready_once: assert property (pready |=> !pready) else $error("pready too long");
	a_ready_wait: assert property (psel && penable && !pready |=> pready) else $error("pready late");
	a_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
	a_write_rdata: assert property (pready && pwrite |-> prdata == 32'h0) else $error("write rdata");
	a_bit6_zero: assert property (pready && !pwrite && paddr == `WDT_OFS_SYSCTL |-> !prdata[6])
		else $error("bit6 set");
	a_keep_copy: assert property (pready && pwrite && paddr == `WDT_OFS_SYSCTL
		|-> ##2 idle_system_clock_keep == $past(pwdata[7], 2)) else $error("keep copy");
	a_reset_pcsp: assert property (!core_reset_n |-> pc_sp_clear) else $error("pc not held");
	a_hold_min: assert property ($fell(core_reset_n) |=> !core_reset_n [*8]) else $error("hold short");
	a_expire_cause: assert property ($rose(watchdog_expired_flag)
		|-> ##[0:2] (!core_reset_n || pc_sp_clear)) else $error("no reset");
	a_kick_clear: assert property (kick_instruction && core_reset_n
		|-> ##[1:2] !watchdog_expired_flag) else $error("flag kept");
endmodule // wdt_props

bind wdt_core wdt_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .kick_instruction(kick_instruction), .core_reset_n(core_reset_n),
	.pc_sp_clear(pc_sp_clear), .watchdog_expired_flag(watchdog_expired_flag),
	.idle_system_clock_keep(idle_system_clock_keep));

`default_nettype wire
